// ### rtl/cag_circ_buf_agu.sv
// circular buffer pointer wrap logic for the x and y data spaces with apb registers
//
// Overview of operation
// [RULE1] pointer updates wrap in hardware automatically
// [RULE2] one x buffer, one y buffer
// [RULE3] software should avoid frame and stack pointers
// [RULE4] buffers generally run in one direction
// [RULE5] both boundaries checked, bidirectional for powers-of-two
// [RULE6] start and end registers bound each buffer
// [RULE7] length implied by end minus start
// [RULE8] x active: select not 15, enable set
// [RULE9] y active: select not 15, enable set
// [RULE10] select 15 disables that space's wrapping
// [RULE11] effective addresses are 16-bit byte addresses
// [RULE12] past end reload start, below start reload end
`timescale 1ns/100ps
module cag_circ_buf_agu #(
   parameter int ADDR_W = 16
) (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire cag_pkg::cag_req_type X_REQ,
   output cag_pkg::cag_res_type X_RES,
   input wire cag_pkg::cag_req_type Y_REQ,
   output cag_pkg::cag_res_type Y_RES
);
   import cag_pkg::*;

   // the decode is 16 bits wide; a wider bus would alias its upper bits onto the map
   if (ADDR_W < 8 || ADDR_W > 16)
   begin : g_bad_addr_w
      $error("cag_circ_buf_agu: ADDR_W must lie between 8 and 16");
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic circ_active(input logic [3:0] sel, input logic en);
      circ_active = (sel != CAG_SEL_OFF) && en; // [RULE8] [RULE9] [RULE10]
   endfunction : circ_active

   function automatic logic [16:0] ptr_sum(input cag_req_type req);
      ptr_sum = {1'b0, req.ptr} + {1'b0, req.step};
   endfunction : ptr_sum

   // upward step that leaves the buffer, carry out of 16 bits counts as past end
   function automatic logic past_end(input cag_req_type req, input logic [15:0] hi);
      logic [16:0] s;
      s = ptr_sum(req);
      past_end = !req.step[15] && (req.step != 16'h0000) && (s[16] || (s[15:0] > hi)); // [RULE12]
   endfunction : past_end

   // downward step that leaves the buffer, missing carry means it went below zero
   function automatic logic below_start(input cag_req_type req, input logic [15:0] lo);
      logic [16:0] s;
      s = ptr_sum(req);
      below_start = req.step[15] && (!s[16] || (s[15:0] < lo)); // [RULE12]
   endfunction : below_start

   // the one place the next pointer is formed; shared by both spaces
   function automatic cag_res_type wrap_ptr(input cag_req_type req, input logic act,
                                            input logic [15:0] lo, input logic [15:0] hi,
                                            input logic word_only);
      cag_res_type r;
      logic [16:0] s;
      s = ptr_sum(req);
      r.valid = req.valid;
      r.wrapped = 1'b0;
      r.ptr = s[15:0]; // [RULE11]
      if (act && past_end(req, hi))
      begin
         r.ptr = lo; // [RULE1] [RULE12]
         r.wrapped = 1'b1;
      end
      else if (act && below_start(req, lo))
      begin
         r.ptr = hi; // [RULE5] [RULE12]
         r.wrapped = 1'b1;
      end
      if (word_only)
      begin
         r.ptr[0] = 1'b0; // y space works on words, the lsb stays clear
      end
      wrap_ptr = r;
   endfunction : wrap_ptr

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   logic [15:0] ctrl_r;
   logic [15:0] ctrl_nxt;
   logic [15:0] x_start_r;
   logic [15:0] x_start_nxt;
   logic [15:0] x_end_r;
   logic [15:0] x_end_nxt;
   logic [15:0] y_start_r;
   logic [15:0] y_start_nxt;
   logic [15:0] y_end_r;
   logic [15:0] y_end_nxt;
   logic [7:0] x_cnt_r;
   logic [7:0] x_cnt_nxt;
   logic [7:0] y_cnt_r;
   logic [7:0] y_cnt_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic slverr_r;
   logic slverr_nxt;

   logic setup_ph;
   logic wr_acc;
   logic [15:0] word_addr;
   logic addr_ok;
   logic x_act;
   logic y_act;
   logic x_match;
   logic y_match;
   logic cnt_clr;
   cag_res_type x_res_r;
   cag_res_type x_res_nxt;
   cag_res_type y_res_r;
   cag_res_type y_res_nxt;

   // merge a 32-bit write into a 16-bit register through the two low lanes
   function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb);
      logic [15:0] v;
      v = old;
      if (strb[0])
      begin
         v[7:0] = wd[7:0];
      end
      if (strb[1])
      begin
         v[15:8] = wd[15:8];
      end
      lane_merge = v;
   endfunction : lane_merge

   assign word_addr = 16'(PADDR);
   assign setup_ph = PSEL && !PENABLE;
   assign wr_acc = PSEL && PENABLE && PWRITE && addr_ok;
   assign addr_ok = (word_addr == CAG_OFS_CTRL) || (word_addr == CAG_OFS_XSTART) ||
                    (word_addr == CAG_OFS_XEND) || (word_addr == CAG_OFS_YSTART) ||
                    (word_addr == CAG_OFS_YEND) || (word_addr == CAG_OFS_STATUS);

   // no wait states: every access completes in its first access cycle
   assign PREADY = 1'b1;
   assign PRDATA = rdata_r;
   assign PSLVERR = slverr_r;

   assign x_act = circ_active(ctrl_r[CAG_XSEL_LSB +: CAG_SEL_W], ctrl_r[CAG_XEN_BIT]);
   assign y_act = circ_active(ctrl_r[CAG_YSEL_LSB +: CAG_SEL_W], ctrl_r[CAG_YEN_BIT]);
   // any pointer except select 15, the off code, may be chosen; frame and stack pointers are not otherwise barred
   assign x_match = x_act && (X_REQ.reg_sel == ctrl_r[CAG_XSEL_LSB +: CAG_SEL_W]); // [RULE2] [RULE3]
   assign y_match = y_act && (Y_REQ.reg_sel == ctrl_r[CAG_YSEL_LSB +: CAG_SEL_W]); // [RULE2]
   assign cnt_clr = wr_acc && (word_addr == CAG_OFS_STATUS);

   always_comb
   begin
      ctrl_nxt = ctrl_r;
      x_start_nxt = x_start_r;
      x_end_nxt = x_end_r;
      y_start_nxt = y_start_r;
      y_end_nxt = y_end_r;
      if (wr_acc)
      begin
         unique case (word_addr)
            CAG_OFS_CTRL: ctrl_nxt = lane_merge(ctrl_r, PWDATA, PSTRB); // [RULE8] [RULE9]
            CAG_OFS_XSTART: x_start_nxt = lane_merge(x_start_r, PWDATA, PSTRB); // [RULE6]
            CAG_OFS_XEND: x_end_nxt = lane_merge(x_end_r, PWDATA, PSTRB); // [RULE6]
            CAG_OFS_YSTART: y_start_nxt = lane_merge(y_start_r, PWDATA, PSTRB); // [RULE6]
            CAG_OFS_YEND: y_end_nxt = lane_merge(y_end_r, PWDATA, PSTRB); // [RULE6]
            default: ;
         endcase
      end
   end

   // read data is fetched in the setup cycle so it is a flop output in the access cycle
   always_comb
   begin
      rdata_nxt = rdata_r;
      slverr_nxt = slverr_r;
      if (setup_ph)
      begin
         rdata_nxt = 32'h0000_0000;
         slverr_nxt = !addr_ok;
         if (!PWRITE)
         begin
            if (word_addr == CAG_OFS_CTRL)
            begin
               rdata_nxt[15:0] = ctrl_r;
            end
            else if (word_addr == CAG_OFS_XSTART)
            begin
               rdata_nxt[15:0] = x_start_r;
            end
            else if (word_addr == CAG_OFS_XEND)
            begin
               rdata_nxt[15:0] = x_end_r;
            end
            else if (word_addr == CAG_OFS_YSTART)
            begin
               rdata_nxt[15:0] = y_start_r;
            end
            else if (word_addr == CAG_OFS_YEND)
            begin
               rdata_nxt[15:0] = y_end_r;
            end
            else if (word_addr == CAG_OFS_STATUS)
            begin
               rdata_nxt[CAG_ST_XACT_BIT] = x_act;
               rdata_nxt[CAG_ST_YACT_BIT] = y_act;
               rdata_nxt[CAG_ST_XCNT_LSB +: CAG_CNT_W] = x_cnt_r;
               rdata_nxt[CAG_ST_YCNT_LSB +: CAG_CNT_W] = y_cnt_r;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // pointer wrap datapath
   // ----------------------------------------------------------------
   // the length is never stored: the comparison against start and end implies it
   always_comb
   begin
      x_res_nxt = wrap_ptr(X_REQ, x_match && X_REQ.valid, x_start_r, x_end_r, 1'b0); // [RULE7]
      y_res_nxt = wrap_ptr(Y_REQ, y_match && Y_REQ.valid, y_start_r, y_end_r, 1'b1); // [RULE7]
      if (!X_REQ.valid)
      begin
         x_res_nxt = '0;
      end
      if (!Y_REQ.valid)
      begin
         y_res_nxt = '0;
      end
   end

   // wrap counters saturate; a wrap in the clearing cycle survives as a count of one
   always_comb
   begin
      x_cnt_nxt = cnt_clr ? 8'h00 : x_cnt_r;
      y_cnt_nxt = cnt_clr ? 8'h00 : y_cnt_r;
      if (x_res_nxt.wrapped && (x_cnt_nxt != CAG_CNT_MAX))
      begin
         x_cnt_nxt = x_cnt_nxt + 8'h01;
      end
      if (y_res_nxt.wrapped && (y_cnt_nxt != CAG_CNT_MAX))
      begin
         y_cnt_nxt = y_cnt_nxt + 8'h01;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RST_B)
      begin
         ctrl_r <= CAG_CTRL_RST;
         x_start_r <= CAG_ADDR_RST;
         x_end_r <= CAG_ADDR_RST;
         y_start_r <= CAG_ADDR_RST;
         y_end_r <= CAG_ADDR_RST;
         x_cnt_r <= 8'h00;
         y_cnt_r <= 8'h00;
         rdata_r <= 32'h0000_0000;
         slverr_r <= 1'b0;
         x_res_r <= '0;
         y_res_r <= '0;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
         x_start_r <= x_start_nxt;
         x_end_r <= x_end_nxt;
         y_start_r <= y_start_nxt;
         y_end_r <= y_end_nxt;
         x_cnt_r <= x_cnt_nxt;
         y_cnt_r <= y_cnt_nxt;
         rdata_r <= rdata_nxt;
         slverr_r <= slverr_nxt;
         x_res_r <= x_res_nxt;
         y_res_r <= y_res_nxt;
      end
   end

   assign X_RES = x_res_r;
   assign Y_RES = y_res_r;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_B);

   sequence x_up_seq;
      X_REQ.valid && x_match && past_end(X_REQ, x_end_r);
   endsequence

   sequence x_dn_seq;
      X_REQ.valid && x_match && below_start(X_REQ, x_start_r);
   endsequence

   sequence xstart_wr_seq;
      PSEL && !PENABLE && PWRITE && (word_addr == CAG_OFS_XSTART) && (PSTRB[1:0] == 2'b11)
      ##1 PSEL && PENABLE;
   endsequence

   x_wrap_up_a: assert property (x_up_seq |=> X_RES.wrapped && X_RES.ptr == $past(x_start_r)) // [RULE12]
      else $error("x pointer past end did not reload start");
   x_wrap_dn_a: assert property (x_dn_seq |=> X_RES.wrapped && X_RES.ptr == $past(x_end_r)) // [RULE12]
      else $error("x pointer below start did not reload end");
   x_sel_off_a: assert property ((ctrl_r[CAG_XSEL_LSB +: CAG_SEL_W] == CAG_SEL_OFF) && X_REQ.valid // [RULE10]
      |=> !X_RES.wrapped && X_RES.ptr == $past(X_REQ.ptr) + $past(X_REQ.step))
      else $error("x wrapped although its select is off");
   y_sel_off_a: assert property ((ctrl_r[CAG_YSEL_LSB +: CAG_SEL_W] == CAG_SEL_OFF) |=> !Y_RES.wrapped) // [RULE10]
      else $error("y wrapped although its select is off");
   x_enable_a: assert property (!ctrl_r[CAG_XEN_BIT] |=> !X_RES.wrapped) // [RULE8]
      else $error("x wrapped while disabled");
   y_enable_a: assert property (!ctrl_r[CAG_YEN_BIT] |=> !Y_RES.wrapped) // [RULE9]
      else $error("y wrapped while disabled");
   y_word_a: assert property (Y_REQ.valid |=> Y_RES.ptr[0] == 1'b0) // [RULE11]
      else $error("y address has its lsb set");
   y_both_dir_a: assert property (Y_REQ.valid && y_match && below_start(Y_REQ, y_start_r) // [RULE5]
      |=> Y_RES.wrapped && Y_RES.ptr == {$past(y_end_r[15:1]), 1'b0})
      else $error("y lower boundary not checked");
   xstart_load_a: assert property (xstart_wr_seq |=> x_start_r == $past(PWDATA[15:0])) // [RULE6]
      else $error("x start register did not load");

endmodule : cag_circ_buf_agu

// ### rtl/cag_pkg.sv
// constants, register map and carrier types of the circular buffer address generator
package cag_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses on the apb bus)
   // ----------------------------------------------------------------
   localparam logic [15:0] CAG_OFS_CTRL = 16'h0000;
   localparam logic [15:0] CAG_OFS_XSTART = 16'h0004;
   localparam logic [15:0] CAG_OFS_XEND = 16'h0008;
   localparam logic [15:0] CAG_OFS_YSTART = 16'h000c;
   localparam logic [15:0] CAG_OFS_YEND = 16'h0010;
   localparam logic [15:0] CAG_OFS_STATUS = 16'h0014;

   // ----------------------------------------------------------------
   // control register fields
   // ----------------------------------------------------------------
   localparam int CAG_XSEL_LSB = 0;
   localparam int CAG_YSEL_LSB = 4;
   localparam int CAG_SEL_W = 4;
   localparam int CAG_YEN_BIT = 14;
   localparam int CAG_XEN_BIT = 15;
   localparam logic [3:0] CAG_SEL_OFF = 4'hf;
   localparam logic [15:0] CAG_CTRL_RST = 16'h00ff;
   localparam logic [15:0] CAG_ADDR_RST = 16'h0000;

   // ----------------------------------------------------------------
   // status register fields
   // ----------------------------------------------------------------
   localparam int CAG_ST_XACT_BIT = 0;
   localparam int CAG_ST_YACT_BIT = 1;
   localparam int CAG_ST_XCNT_LSB = 16;
   localparam int CAG_ST_YCNT_LSB = 24;
   localparam int CAG_CNT_W = 8;
   localparam logic [7:0] CAG_CNT_MAX = 8'hff;

   // ----------------------------------------------------------------
   // carriers between the core datapath and the generator
   // ----------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic [3:0] reg_sel;
      logic [15:0] ptr;
      logic [15:0] step;
   } cag_req_type;

   typedef struct packed {
      logic valid;
      logic wrapped;
      logic [15:0] ptr;
   } cag_res_type;

endpackage : cag_pkg

// ### dv/cag_core_model.sv
// core datapath model that issues pointer updates to the generator
`timescale 1ns/100ps
module cag_core_model (
   input wire logic CLK,
   output cag_pkg::cag_req_type X_REQ,
   output cag_pkg::cag_req_type Y_REQ
);
   import cag_pkg::*;

   initial
   begin
      X_REQ = '0;
      Y_REQ = '0;
   end

   // ----------------------------------------------------------------
   // one update per call, held for exactly one edge
   // ----------------------------------------------------------------
   // callers never pick the frame or stack pointer
   task automatic send(input logic y, input logic [3:0] sel, input logic [15:0] ptr, input logic [15:0] step);
      cag_req_type r;
      r = '{valid: 1'b1, reg_sel: sel, ptr: ptr, step: step};
      if (y)
         Y_REQ <= r;
      else
         X_REQ <= r;
      @(posedge CLK);
      // idle fields flip so a result copied from a dead request shows
      r = '{valid: 1'b0, reg_sel: ~sel, ptr: ~ptr, step: ~step};
      if (y)
         Y_REQ <= r;
      else
         X_REQ <= r;
   endtask : send
endmodule : cag_core_model

// ### dv/tb.sv
// register and pointer wrap testbench for the circular buffer address generator
`timescale 1ns/100ps
module tb;
   import cag_pkg::*;
   logic CLK, RST_B, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
   logic [15:0] PADDR, ctl, xs, xe, ys, ye;
   logic [31:0] PWDATA, PRDATA, rd;
   logic [3:0] PSTRB;
   logic [7:0] xcnt, ycnt;
   cag_req_type X_REQ, Y_REQ;
   cag_res_type X_RES, Y_RES;
   int mismatches, n_checks;

   cag_circ_buf_agu dut (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .X_REQ(X_REQ), .X_RES(X_RES), .Y_REQ(Y_REQ), .Y_RES(Y_RES));
   cag_core_model core (.CLK(CLK), .X_REQ(X_REQ), .Y_REQ(Y_REQ));

   initial
   begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic tally_and_finish();
      if (mismatches == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
      int i;
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      PSTRB <= s;
      @(posedge CLK);
      PENABLE <= 1'b1;
      for (i = 0; i < 16; i++)
      begin
         @(posedge CLK);
         if (PREADY === 1'b1)
            break;
      end
      if (i == 16)
      begin
         mismatches++;
         tally_and_finish();
      end
      else
      begin
         rd = PRDATA;
         err = PSLVERR;
         PSEL <= 1'b0;
         PENABLE <= 1'b0;
         @(posedge CLK);
      end
   endtask : apb

   task automatic rchk(input logic [15:0] a, input logic [31:0] exp, input logic experr);
      apb(1'b0, a, 32'h0, 4'h0);
      check("read data", rd, exp);
      check("slave error", {31'h0, err}, {31'h0, experr});
   endtask : rchk

   // expected result worked out from the shadow registers
   task automatic pt(input logic y, input logic [3:0] sel, input logic [15:0] ptr, input logic [15:0] step);
      logic [3:0] f;
      logic act, w;
      logic [16:0] s;
      logic [15:0] lo, hi, np;
      cag_res_type r;
      f = y ? ctl[7:4] : ctl[3:0];
      act = (f == sel) && (f != 4'hf) && (y ? ctl[14] : ctl[15]);
      lo = y ? ys : xs;
      hi = y ? ye : xe;
      s = {1'b0, ptr} + {1'b0, step};
      w = act && ((!step[15] && step != 16'h0 && (s[16] || s[15:0] > hi)) || (step[15] && (!s[16] || s[15:0] < lo)));
      np = w ? (step[15] ? hi : lo) : s[15:0];
      np[0] = np[0] & ~y;
      core.send(y, sel, ptr, step);
      #1;
      r = y ? Y_RES : X_RES;
      check("pointer result", {14'h0, r}, {14'h0, 1'b1, w, np});
      xcnt = xcnt + 8'(w & ~y);
      ycnt = ycnt + 8'(w & y);
      @(posedge CLK);
   endtask : pt

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      {RST_B, PSEL, PENABLE, PWRITE, PADDR, PWDATA, PSTRB} = '0;
      {mismatches, n_checks, xcnt, ycnt} = '0;
      {ctl, xs, xe, ys, ye} = {CAG_CTRL_RST, 64'h0};
      repeat (16) @(posedge CLK);
      RST_B <= 1'b1;
      @(posedge CLK);
      rchk(CAG_OFS_CTRL, 32'h0000_00ff, 1'b0);
      rchk(CAG_OFS_XSTART, 32'h0, 1'b0);
      rchk(CAG_OFS_YEND, 32'h0, 1'b0);
      rchk(CAG_OFS_STATUS, 32'h0, 1'b0);
      rchk(16'h0018, 32'h0, 1'b1);
      // upper lane only: enables set, selects stay at the off code
      apb(1'b1, CAG_OFS_CTRL, 32'h0000_c0d2, 4'h2);
      ctl = 16'hc0ff;
      rchk(CAG_OFS_CTRL, 32'h0000_c0ff, 1'b0);
      pt(1'b0, 4'hf, 16'hfffe, 16'h0002);
      pt(1'b1, 4'hf, 16'hfffe, 16'h0002);
      // power-of-two buffers so both boundaries are legal
      {xs, xe, ys, ye, ctl} = {16'h1000, 16'h100e, 16'h2000, 16'h201e, 16'hc0d2};
      apb(1'b1, CAG_OFS_XSTART, 32'hffff_1000, 4'hf);
      apb(1'b1, CAG_OFS_XEND, {16'h0, xe}, 4'hf);
      apb(1'b1, CAG_OFS_YSTART, {16'h0, ys}, 4'hf);
      apb(1'b1, CAG_OFS_YEND, {16'h0, ye}, 4'hf);
      apb(1'b1, CAG_OFS_CTRL, {16'h0, ctl}, 4'hf);
      rchk(CAG_OFS_XSTART, 32'h0000_1000, 1'b0);
      pt(1'b0, 4'h2, 16'h100e, 16'h0002);
      pt(1'b0, 4'h2, 16'h1000, 16'hfffe);
      pt(1'b0, 4'h2, 16'h1004, 16'h0002);
      pt(1'b0, 4'h3, 16'h100e, 16'h0002);
      pt(1'b1, 4'hd, 16'h201e, 16'h0002);
      pt(1'b1, 4'hd, 16'h2000, 16'hfffe);
      pt(1'b1, 4'hd, 16'h2011, 16'h0004);
      rchk(CAG_OFS_STATUS, {ycnt, xcnt, 16'h0003}, 1'b0);
      apb(1'b1, CAG_OFS_STATUS, 32'h0, 4'hf);
      {xcnt, ycnt} = '0;
      rchk(CAG_OFS_STATUS, 32'h0000_0003, 1'b0);
      ctl = 16'h40d2;
      apb(1'b1, CAG_OFS_CTRL, {16'h0, ctl}, 4'hf);
      pt(1'b0, 4'h2, 16'h100e, 16'h0002);
      pt(1'b1, 4'hd, 16'h201e, 16'h0002);
      ctl = 16'h80f2;
      apb(1'b1, CAG_OFS_CTRL, {16'h0, ctl}, 4'hf);
      pt(1'b1, 4'hf, 16'h201e, 16'h0002);
      rchk(CAG_OFS_STATUS, {ycnt, xcnt, 16'h0001}, 1'b0);
      // full 64 Kbyte buffer, both ends
      {xs, xe} = {16'h0000, 16'hfffe};
      apb(1'b1, CAG_OFS_XSTART, 32'h0, 4'hf);
      apb(1'b1, CAG_OFS_XEND, {16'h0, xe}, 4'hf);
      pt(1'b0, 4'h2, 16'hfffe, 16'h0002);
      pt(1'b0, 4'h2, 16'h0000, 16'hfffe);
      tally_and_finish();
   end
endmodule : tb
